// [rtl/asp2_serial_port.sv]
// full-duplex asynchronous serial port with byte register set
// Summary of operation
// - tx done flag sets after last stop bit when holding register empty
// - tx done flag clears when holding byte moves into shift register
// - interrupt when any flag and its enable are both one
// - tx vacant sets on move to shifter, clears on holding write
// - transmitter and receiver run only while run bit is one
// - rx error set at stop bit on parity, overrun or stop error
// - rx ready sets at stop bit, clears on receive holding read
// - one stop bit sent when select is 0, two when 1
// - receiver checks first stop bit only; low next bit starts frame
// - mode 0 bit period is (divider+1) times 4 or 16 cycles
// - divider zero selects mode 1, prescale ignored there
// - source field picks system, external pin, low or high oscillator
// - mode 0 parity type: 0 even, 1 odd, both directions
// - mode 0 parity bit present only when enabled; never in mode 1
// - wakeup flag sets when its enable is one and rx pin low
// - transmit start copies holding register into shift register
// - receive end moves assembled byte into receive holding register
// - eight data bits per frame, least significant first
// - mode 1 runs from 32.768 kHz crystal at 9600 bps
// - one cycle equals one period of selected baud clock source
`include "asp2_defines.svh"
`default_nettype none
module asp2_serial_port
  import asp2_pkg::*;
#(
  parameter int XTAL_HZ = `ASP2_MODE1_XTAL_HZ,
  parameter int MODE1_BPS = `ASP2_MODE1_BPS
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // baud clock sources, asynchronous
  input wire logic external_baud_pin_i,
  input wire logic low_speed_oscillator_i,
  input wire logic high_speed_oscillator_i,
  // serial lines
  output logic transmit_pin_o,
  input wire logic receive_pin_i,
  // interrupt request
  output logic irq_o
);
  // mode 1 bit period in crystal cycles, nearest whole count
  localparam int M1_DIV = (XTAL_HZ + MODE1_BPS / 2) / MODE1_BPS;
  localparam logic [12:0] M1_PERIOD = 13'(M1_DIV);

  // exact match of one register offset
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] ofs);
    return a == ofs;
  endfunction

  // last count of a bit period, shared by both directions
  function automatic logic last_count(input logic [12:0] cnt,
                                      input logic [12:0] period);
    return cnt == period - 13'h0001;
  endfunction

  // bit counter step, wrapping to zero at the end of a bit
  function automatic logic [12:0] count_step(input logic [12:0] cnt,
                                             input logic wrap);
    return wrap ? 13'h0000 : cnt + 13'h0001;
  endfunction

  // hardware flag: set beats clear
  function automatic logic flag_next(input logic set, input logic clr,
                                     input logic old);
    return set | (old & ~clr);
  endfunction

  // flag that software can only clear by writing zero; set wins
  function automatic logic sticky_next(input logic set, input logic wr,
                                       input logic wbit, input logic old);
    return set | (old & (~wr | wbit));
  endfunction

  asp2_bus_s bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // synchronisers for everything arriving from outside this clock
  logic [1:0] ext_sy_reg, lso_sy_reg, hso_sy_reg, rx_sy_reg;
  logic src_prev_reg;
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_sy_reg <= 2'h0;
      lso_sy_reg <= 2'h0;
      hso_sy_reg <= 2'h0;
      // line resets high so no false start follows reset
      rx_sy_reg <= 2'h3;
    end else begin
      ext_sy_reg <= {ext_sy_reg[0], external_baud_pin_i};
      lso_sy_reg <= {lso_sy_reg[0], low_speed_oscillator_i};
      hso_sy_reg <= {hso_sy_reg[0], high_speed_oscillator_i};
      rx_sy_reg <= {rx_sy_reg[0], receive_pin_i};
    end
  end
  wire rx_line = rx_sy_reg[1];

  // registers
  logic [7:0] cs_reg, fc_reg, thr_reg, rhr_reg, bg_reg, rdata_reg;
  logic irq_reg;
  wire run = cs_reg[`ASP2_CS_RUN];
  wire mode1 = (bg_reg == 8'h00);
  wire par_en = fc_reg[`ASP2_FC_PARITY_EN] & ~mode1;
  wire par_odd = fc_reg[`ASP2_FC_PARITY_TYPE] & ~mode1;
  wire [1:0] src_sel = fc_reg[`ASP2_FC_SRC_HI:`ASP2_FC_SRC_LO];

  // source selection, one enable per source rising edge
  logic src_lvl;
  always_comb begin
    case (src_sel)
      2'b00: src_lvl = 1'b0;
      2'b01: src_lvl = ext_sy_reg[1];
      2'b10: src_lvl = lso_sy_reg[1];
      2'b11: src_lvl = hso_sy_reg[1];
      default: src_lvl = 1'b0;
    endcase
  end
  // system clock source ticks every cycle; others on their rising edge
  wire cyc_tick = (src_sel == 2'b00) | (src_lvl & ~src_prev_reg);

  // bit period in selected cycles
  wire [12:0] bg_plus = {5'h00, bg_reg} + 13'h0001;
  wire [12:0] m0_period = fc_reg[`ASP2_FC_PRESCALE]
    ? 13'(bg_plus << `ASP2_PRESCALE_SHIFT_HI)
    : 13'(bg_plus << `ASP2_PRESCALE_SHIFT_LO);
  // mode 1 assumes the low speed crystal is selected
  wire [12:0] bit_period = mode1 ? M1_PERIOD : m0_period;

  // register decode
  wire sel_cs = hit(bus.addr, `ASP2_OFS_CONTROL_STATUS);
  wire sel_fc = hit(bus.addr, `ASP2_OFS_FORMAT_CONTROL);
  wire sel_th = hit(bus.addr, `ASP2_OFS_TRANSMIT_HOLDING);
  wire sel_rh = hit(bus.addr, `ASP2_OFS_RECEIVE_HOLDING);
  wire sel_bg = hit(bus.addr, `ASP2_OFS_BAUD_DIVIDER);
  wire wr_cs = bus.wr & sel_cs;
  wire wr_fc = bus.wr & sel_fc;
  wire wr_th = bus.wr & sel_th;
  wire rd_rh = bus.rd & sel_rh;
  wire [7:0] rd_mux = sel_cs ? cs_reg : sel_fc ? fc_reg : sel_th ? thr_reg
    : sel_rh ? rhr_reg : sel_bg ? bg_reg : 8'h00;

  // transmitter
  asp2_state_e tx_st_reg;
  logic [12:0] tx_cnt_reg;
  logic [7:0] tsh_reg;
  logic [3:0] tx_bit_reg;
  logic tx_par_reg, tx_line_reg, tx_pend_reg, tx_stop2_reg;
  wire tx_bit_end = cyc_tick & last_count(tx_cnt_reg, bit_period);
  // transmit start: holding full and shifter idle
  wire tx_load = run & tx_pend_reg & (tx_st_reg == ASP2_IDLE);
  wire tx_last_stop = (tx_st_reg == ASP2_STOP) & tx_bit_end
    & (tx_stop2_reg | ~fc_reg[`ASP2_FC_STOP_LEN]);

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_st_reg <= ASP2_IDLE;
      tx_cnt_reg <= 13'h0000;
      tsh_reg <= 8'h00;
      tx_bit_reg <= 4'h0;
      tx_par_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      tx_stop2_reg <= 1'b0;
    end else if (!run) begin
      tx_st_reg <= ASP2_IDLE;
      tx_cnt_reg <= 13'h0000;
      tx_line_reg <= 1'b1;
    end else if (tx_load) begin
      tsh_reg <= thr_reg;
      tx_par_reg <= par_odd;
      tx_st_reg <= ASP2_START;
      tx_cnt_reg <= 13'h0000;
      tx_line_reg <= 1'b0;
    end else if (tx_st_reg != ASP2_IDLE && cyc_tick) begin
      tx_cnt_reg <= count_step(tx_cnt_reg, tx_bit_end);
      if (tx_bit_end) begin
        case (tx_st_reg)
          ASP2_START: begin
            tx_st_reg <= ASP2_DATA;
            tx_bit_reg <= 4'h0;
            tx_line_reg <= tsh_reg[0];
            tx_par_reg <= tx_par_reg ^ tsh_reg[0];
            tsh_reg <= {1'b0, tsh_reg[7:1]};
          end
          ASP2_DATA: begin
            if (tx_bit_reg == `ASP2_DATA_BITS - 4'd1) begin
              tx_st_reg <= par_en ? ASP2_PARITY : ASP2_STOP;
              tx_line_reg <= par_en ? tx_par_reg : 1'b1;
              tx_stop2_reg <= 1'b0;
            end else begin
              tx_bit_reg <= tx_bit_reg + 4'd1;
              tx_line_reg <= tsh_reg[0];
              tx_par_reg <= tx_par_reg ^ tsh_reg[0];
              tsh_reg <= {1'b0, tsh_reg[7:1]};
            end
          end
          ASP2_PARITY: begin
            tx_st_reg <= ASP2_STOP;
            tx_line_reg <= 1'b1;
            tx_stop2_reg <= 1'b0;
          end
          ASP2_STOP: begin
            if (tx_last_stop) begin
              tx_st_reg <= ASP2_IDLE;
            end else begin
              tx_stop2_reg <= 1'b1;
            end
          end
          default: tx_st_reg <= ASP2_IDLE;
        endcase
      end
    end
  end

  // receiver
  asp2_state_e rx_st_reg;
  logic [12:0] rx_cnt_reg;
  logic [7:0] rsh_reg;
  logic [3:0] rx_bit_reg;
  logic rx_par_reg;
  wire [12:0] half_period = {1'b0, bit_period[12:1]};
  wire rx_mid = cyc_tick & (rx_cnt_reg == half_period);
  wire rx_bit_end = cyc_tick & last_count(rx_cnt_reg, bit_period);
  // sample at mid bit; the stop state ends right at its sample point
  wire rx_stop_smp = (rx_st_reg == ASP2_STOP) & rx_mid;
  wire rx_perr = par_en & rx_par_reg;
  wire rx_ovr = cs_reg[`ASP2_CS_RX_READY] & ~rd_rh;
  wire rx_err = rx_perr | rx_ovr | ~rx_line;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_st_reg <= ASP2_IDLE;
      rx_cnt_reg <= 13'h0000;
      rsh_reg <= 8'h00;
      rx_bit_reg <= 4'h0;
      rx_par_reg <= 1'b0;
    end else if (!run) begin
      rx_st_reg <= ASP2_IDLE;
      rx_cnt_reg <= 13'h0000;
    end else if (rx_st_reg == ASP2_IDLE) begin
      rx_cnt_reg <= 13'h0000;
      if (!rx_line) begin
        rx_st_reg <= ASP2_START;
        rx_par_reg <= par_odd;
      end
    end else if (cyc_tick) begin
      rx_cnt_reg <= count_step(rx_cnt_reg, rx_bit_end);
      case (rx_st_reg)
        ASP2_START: begin
          if (rx_mid && rx_line) begin
            rx_st_reg <= ASP2_IDLE;
          end else if (rx_bit_end) begin
            rx_st_reg <= ASP2_DATA;
            rx_bit_reg <= 4'h0;
          end
        end
        ASP2_DATA: begin
          if (rx_mid) begin
            rsh_reg <= {rx_line, rsh_reg[7:1]};
            rx_par_reg <= rx_par_reg ^ rx_line;
          end
          if (rx_bit_end) begin
            if (rx_bit_reg == `ASP2_DATA_BITS - 4'd1) begin
              rx_st_reg <= par_en ? ASP2_PARITY : ASP2_STOP;
            end else begin
              rx_bit_reg <= rx_bit_reg + 4'd1;
            end
          end
        end
        ASP2_PARITY: begin
          if (rx_mid) begin
            rx_par_reg <= rx_par_reg ^ rx_line;
          end
          if (rx_bit_end) begin
            rx_st_reg <= ASP2_STOP;
          end
        end
        ASP2_STOP: begin
          // only the first stop bit is checked; idle hunts the next start
          if (rx_mid) begin
            rx_st_reg <= ASP2_IDLE;
          end
        end
        default: rx_st_reg <= ASP2_IDLE;
      endcase
    end
  end

  // status flags; hardware set wins over any clear, except tx vacant, where a holding write in the load cycle wins
  wire tx_done_nx = tx_last_stop ? ~tx_pend_reg & ~wr_th
    : tx_load ? 1'b0
    : cs_reg[`ASP2_CS_TX_DONE];
  // a write in the load cycle leaves the holding register full
  wire tx_vac_nx = flag_next(tx_load & ~wr_th, wr_th,
    cs_reg[`ASP2_CS_TX_VACANT]);
  wire rx_rdy_nx = flag_next(rx_stop_smp, rd_rh,
    cs_reg[`ASP2_CS_RX_READY]);
  // error flag is software cleared by writing zero
  wire rx_err_nx = sticky_next(rx_stop_smp & rx_err, wr_cs,
    bus.wdata[`ASP2_CS_RX_ERROR], cs_reg[`ASP2_CS_RX_ERROR]);
  wire wup_ie = fc_reg[`ASP2_FC_WAKEUP_IE];
  wire wup_nx = sticky_next(wup_ie & ~rx_line, wr_fc,
    bus.wdata[`ASP2_FC_WAKEUP], fc_reg[`ASP2_FC_WAKEUP]);
  wire [7:0] cs_wr = wr_cs ? bus.wdata : cs_reg;
  wire [7:0] cs_next = {
    tx_done_nx,
    cs_wr[`ASP2_CS_TX_DONE_IE],
    tx_vac_nx,
    cs_wr[`ASP2_CS_TX_VACANT_IE],
    cs_wr[`ASP2_CS_RUN],
    rx_err_nx,
    rx_rdy_nx,
    cs_wr[`ASP2_CS_RX_IE]
  };
  wire [7:0] fc_wr = wr_fc ? bus.wdata : fc_reg;
  wire [7:0] fc_next = {
    fc_wr[7:2],
    wup_nx,
    fc_wr[`ASP2_FC_WAKEUP_IE]
  };
  wire irq_done = cs_reg[`ASP2_CS_TX_DONE] & cs_reg[`ASP2_CS_TX_DONE_IE];
  wire irq_vac = cs_reg[`ASP2_CS_TX_VACANT] & cs_reg[`ASP2_CS_TX_VACANT_IE];
  wire irq_rx = cs_reg[`ASP2_CS_RX_READY] & cs_reg[`ASP2_CS_RX_IE];
  wire irq_wup = fc_reg[`ASP2_FC_WAKEUP] & fc_reg[`ASP2_FC_WAKEUP_IE];
  // one shared request line, so all four sources are or-ed
  wire irq_next = irq_done | irq_vac | irq_rx | irq_wup;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_reg <= `ASP2_RST_CONTROL_STATUS;
      fc_reg <= `ASP2_RST_FORMAT_CONTROL;
      thr_reg <= `ASP2_RST_BYTE;
      rhr_reg <= `ASP2_RST_BYTE;
      bg_reg <= `ASP2_RST_BYTE;
      rdata_reg <= `ASP2_RST_BYTE;
      tx_pend_reg <= 1'b0;
      irq_reg <= 1'b0;
      src_prev_reg <= 1'b0;
    end else begin
      cs_reg <= cs_next;
      fc_reg <= fc_next;
      irq_reg <= irq_next;
      src_prev_reg <= src_lvl;
      // zero outside the answer cycle keeps the read port quiet
      rdata_reg <= bus.rd ? rd_mux : 8'h00;
      if (wr_th) begin
        thr_reg <= bus.wdata;
      end
      if (bus.wr && sel_bg) begin
        bg_reg <= bus.wdata;
      end
      // a write in the load cycle refills the holding register
      tx_pend_reg <= wr_th | (tx_pend_reg & ~tx_load);
      if (rx_stop_smp) begin
        rhr_reg <= rsh_reg;
      end
    end
  end

  assign rdata_o = rdata_reg;
  assign transmit_pin_o = tx_line_reg;
  assign irq_o = irq_reg;
endmodule
`default_nettype wire

// [rtl/asp2_defines.svh]
// register offsets, field positions, reset values and timing counts
`ifndef ASP2_DEFINES_SVH
`define ASP2_DEFINES_SVH
`define ASP2_OFS_CONTROL_STATUS 16'h7f6c
`define ASP2_OFS_FORMAT_CONTROL 16'h7f6d
`define ASP2_OFS_TRANSMIT_HOLDING 16'h7f6e
`define ASP2_OFS_RECEIVE_HOLDING 16'h7f6f
`define ASP2_OFS_BAUD_DIVIDER 16'h7f74
`define ASP2_RST_CONTROL_STATUS 8'h20
`define ASP2_RST_FORMAT_CONTROL 8'h00
`define ASP2_RST_BYTE 8'h00
`define ASP2_CS_TX_DONE 7
`define ASP2_CS_TX_DONE_IE 6
`define ASP2_CS_TX_VACANT 5
`define ASP2_CS_TX_VACANT_IE 4
`define ASP2_CS_RUN 3
`define ASP2_CS_RX_ERROR 2
`define ASP2_CS_RX_READY 1
`define ASP2_CS_RX_IE 0
`define ASP2_FC_STOP_LEN 7
`define ASP2_FC_PRESCALE 6
`define ASP2_FC_SRC_HI 5
`define ASP2_FC_SRC_LO 4
`define ASP2_FC_PARITY_TYPE 3
`define ASP2_FC_PARITY_EN 2
`define ASP2_FC_WAKEUP 1
`define ASP2_FC_WAKEUP_IE 0
`define ASP2_PRESCALE_SHIFT_LO 2
`define ASP2_PRESCALE_SHIFT_HI 4
`define ASP2_MODE1_XTAL_HZ 32768
`define ASP2_MODE1_BPS 9600
`define ASP2_DATA_BITS 4'd8
`endif

// [rtl/asp2_pkg.sv]
// types shared by the serial port
`default_nettype none
package asp2_pkg;
  typedef enum logic [2:0] {
    ASP2_IDLE = 3'b000,
    ASP2_START = 3'b001,
    ASP2_DATA = 3'b010,
    ASP2_PARITY = 3'b011,
    ASP2_STOP = 3'b100
  } asp2_state_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } asp2_bus_s;
endpackage
`default_nettype wire

// [verif/asp2_serial_port_assertions.sv]
// checker of register port and line behaviour at the serial port pins
`include "asp2_defines.svh"
`default_nettype none
module asp2_serial_port_assertions (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // pins
  input wire logic transmit_pin_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic cs = addr_i == `ASP2_OFS_CONTROL_STATUS;
  wire logic fc = addr_i == `ASP2_OFS_FORMAT_CONTROL;
  wire logic th = addr_i == `ASP2_OFS_TRANSMIT_HOLDING;
  wire logic rh = addr_i == `ASP2_OFS_RECEIVE_HOLDING;
  wire logic bd = addr_i == `ASP2_OFS_BAUD_DIVIDER;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  ready_clear_a: assert property (
    rd_i && rh ##1 rd_i && cs |=> !rdata_o[1])
    else $error("rx ready kept after data read");
  vacant_clear_a: assert property (
    wr_i && th ##1 rd_i && cs |=> !rdata_o[5])
    else $error("tx vacant kept after holding write");
  irq_flags_a: assert property (
    rd_i && cs |=> irq_o || !((rdata_o[7] && rdata_o[6]) ||
    (rdata_o[5] && rdata_o[4]) || (rdata_o[1] && rdata_o[0])))
    else $error("flag with enable gave no request");
  run_stop_a: assert property (
    wr_i && cs && !wdata_i[3] |-> ##4 transmit_pin_o [*4])
    else $error("line active after stop");
  idle_high_a: assert property (
    rd_i && cs ##1 !rdata_o[3] |=> ##1 transmit_pin_o)
    else $error("line low while stopped");
  cs_bits_a: assert property (
    wr_i && cs ##1 rd_i && cs |=>
    (rdata_o & 8'h59) == ($past(wdata_i, 2) & 8'h59))
    else $error("control bits not stored");
  format_a: assert property (
    wr_i && fc ##1 rd_i && fc |=> rdata_o[7:2] == $past(wdata_i[7:2], 2))
    else $error("format bits not stored");
  divider_a: assert property (
    wr_i && bd ##1 rd_i && bd |=> rdata_o == $past(wdata_i, 2))
    else $error("divider not stored");
endmodule
bind asp2_serial_port asp2_serial_port_assertions u_chk (.ref_clk_i,
  .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .transmit_pin_o, .irq_o);
`default_nettype wire

// [verif/asp2_line_peer.sv]
// remote serial transceiver model on the two serial lines
`default_nettype none
module asp2_line_peer (
  // clock and lines
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  realtime t0;
  initial line_o = 1'b1;
  // low start, bits lsb first, one high stop; bits counted in clk_i
  task automatic send(input logic [8:0] d, input int per, input int nb);
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (per) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      line_o <= d[i];
      repeat (per) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (per) @(posedge clk_i);
  endtask
  // samples mid bit: start, nb bits, first stop; spare bits read high
  task automatic get(output logic [10:0] f, input int per, input int nb);
    f = '1;
    @(negedge line_i);
    t0 = $realtime;
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i <= nb + 1; i++) begin
      f[i] = line_i;
      if (i <= nb)
        repeat (per) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// [verif/tb_async_serial_port_two.sv]
// self-checking bench for the serial port
`include "asp2_defines.svh"
`default_nettype none
module tb_async_serial_port_two;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CS = `ASP2_OFS_CONTROL_STATUS;
  localparam logic [15:0] FC = `ASP2_OFS_FORMAT_CONTROL;
  localparam logic [15:0] TH = `ASP2_OFS_TRANSMIT_HOLDING;
  localparam logic [15:0] RH = `ASP2_OFS_RECEIVE_HOLDING;
  localparam logic [15:0] BD = `ASP2_OFS_BAUD_DIVIDER;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic external_baud_pin_i = 1'b0, low_speed_oscillator_i = 1'b0;
  logic high_speed_oscillator_i = 1'b0, receive_pin_i;
  logic transmit_pin_o, irq_o;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00, rdata_o;
  int errors = 0, compares = 0, cyc = 0, nfall = 0;
  asp2_serial_port DUT (.ref_clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .external_baud_pin_i, .low_speed_oscillator_i,
    .high_speed_oscillator_i, .transmit_pin_o, .receive_pin_i, .irq_o);
  asp2_line_peer peer (.clk_i(ref_clk_i), .line_i(transmit_pin_o),
    .line_o(receive_pin_i));
  // three unrelated baud sources: 20, 40 and 30 ns
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  initial forever #10 external_baud_pin_i = ~external_baud_pin_i;
  initial forever #20 low_speed_oscillator_i = ~low_speed_oscillator_i;
  initial forever #15 high_speed_oscillator_i = ~high_speed_oscillator_i;
  always @(negedge transmit_pin_o) nfall++;
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input logic [10:0] got, input logic [10:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // tasks start and end 1 ns after an edge, so strobes never collide
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [10:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = {3'b000, rdata_o};
  endtask
  task automatic poll(input logic [15:0] a, input logic [7:0] m,
                      output logic [10:0] d);
    int n;
    n = 0;
    rd(a, d);
    while ((d[7:0] & m) == 8'h00 && n < 3000) begin
      rd(a, d);
      n++;
    end
    if (n == 3000) begin
      errors++;
      $display("[FAIL] %0t poll timeout", $time);
    end
  endtask
  function automatic logic [10:0] frm(logic [7:0] d, logic pe, logic od);
    return pe ? {1'b1, ^d ^ od, d, 1'b0} : {2'b11, d, 1'b0};
  endfunction
  initial begin
    logic [10:0] b, f1, f2;
    logic [7:0] d1;
    logic [15:0] av[6] = '{CS, FC, TH, RH, BD, 16'h7f70};
    logic [7:0] rv[6] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] fv[7] = '{8'h00, 8'h8c, 8'h44, 8'h10, 8'h20, 8'h2c, 8'h30};
    logic [7:0] bv[7] = '{8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
    logic [7:0] rf[4] = '{8'h00, 8'h04, 8'h0c, 8'h80};
    int per, nb, sp[4] = '{1, 4, 8, 6};
    realtime t1, dt;
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr(RH, 8'hff);
    wr(16'h7f70, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(av[i], b);
      chk(b, {3'b000, rv[i]}, "reset value");
    end
    wr(CS, 8'h59);
    rd(CS, b);
    chk(b, 11'h079, "control bits");
    @(posedge ref_clk_i);
    #1;
    chk({10'h000, irq_o}, 11'h001, "vacant irq");
    wr(CS, 8'h48);
    repeat (2) @(posedge ref_clk_i);
    chk({10'h000, irq_o}, 11'h000, "irq masked");
    for (int k = 0; k < 7; k++) begin
      wr(FC, fv[k]);
      rd(FC, b);
      chk(b & 11'h0fd, {3'b000, fv[k] & 8'hfd}, "format");
      wr(BD, bv[k]);
      rd(BD, b);
      chk(b, {3'b000, bv[k]}, "divider");
      per = bv[k] == 8'h00 ? 3 : (bv[k] + 1) * (fv[k][6] ? 16 : 4);
      per = per * sp[fv[k][5:4]];
      nb = (bv[k] != 8'h00 && fv[k][2]) ? 9 : 8;
      d1 = {5'h0b, 3'(k)};
      fork
        begin
          wr(TH, d1);
          poll(CS, 8'h20, b);
          chk(b & 11'h080, 11'h000, "done cleared");
          wr(TH, ~d1);
        end
        begin
          peer.get(f1, per, nb);
          t1 = peer.t0;
          peer.get(f2, per, nb);
        end
      join
      chk(f1, frm(d1, nb == 9, fv[k][3]), "frame one");
      chk(f2, frm(~d1, nb == 9, fv[k][3]), "frame two");
      dt = peer.t0 - t1 - (2 + nb + fv[k][7]) * per * 5.0;
      chk({10'h000, dt < per * 2.5 && dt > -per * 2.5}, 11'h001,
          "frame length");
      poll(CS, 8'h80, b);
      chk(b & 11'h0a0, 11'h0a0, "done and vacant");
      @(posedge ref_clk_i);
      #1;
      chk({10'h000, irq_o}, 11'h001, "done irq");
    end
    wr(CS, 8'h09);
    wr(BD, 8'h02);
    for (int k = 0; k < 4; k++) begin
      d1 = {3'(k), 5'h13};
      wr(FC, rf[k]);
      peer.send({^d1 ^ rf[k][3] ^ (k == 2), d1}, 12, rf[k][2] ? 9 : 8);
      if (k == 3)
        peer.send({1'b0, ~d1}, 12, 8);
      poll(CS, 8'h02, b);
      chk({10'h000, irq_o}, 11'h001, "rx irq");
      chk(b & 11'h006, k > 1 ? 11'h006 : 11'h002, "rx flags");
      rd(RH, b);
      chk(b, {3'b000, k == 3 ? ~d1 : d1}, "rx data");
      rd(CS, b);
      chk(b & 11'h002, 11'h000, "ready cleared");
      wr(CS, 8'h09);
      repeat (2) @(posedge ref_clk_i);
      chk({10'h000, irq_o}, 11'h000, "rx irq clear");
    end
    wr(FC, 8'h01);
    rd(FC, b);
    chk(b & 11'h002, 11'h000, "no wakeup");
    fork
      peer.send(9'h000, 12, 8);
      begin
        poll(FC, 8'h02, b);
        chk({10'h000, irq_o}, 11'h001, "wakeup irq");
      end
    join
    wr(FC, 8'h00);
    rd(RH, b);
    wr(CS, 8'h00);
    nb = nfall;
    wr(TH, 8'h33);
    peer.send(9'h055, 12, 8);
    rd(CS, b);
    chk(b & 11'h002, 11'h000, "stopped rx");
    chk(11'(nfall - nb), 11'h000, "stopped tx");
    give_verdict();
  end
endmodule
`default_nettype wire
